// ==== core/epi_top.sv ====
// external pin interrupt logic with axi4-lite registers and sleep wake-up
`timescale 1ns/1ns
module epi_top (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// pins
	input wire logic [2:0] pin_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	// core interrupt side
	output logic [2:0] irq_req,
	input wire logic [2:0] vector_ack,
	output logic core_asleep,
	output logic io_clk_run,
	output logic irq,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic [2:0] flag;
		logic [2:0] req;
		logic [1:0] sense0;
		logic [1:0] sense1;
		logic pol2;
		logic [2:0] ena;
		logic gie;
		logic [2:0] drv_val;
		logic [2:0] drv_dir;
		logic deep;
		logic [1:0] startup_fuse;
		epi_pkg::epi_pwr_t pwr;
		logic [6:0] wdt_cnt;
		logic [1:0] smp_cnt;
		logic [5:0] tick_cnt;
		logic [3:0] stat;
		logic [3:0] mask;
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} epi_state_t;

	epi_state_t st_r;
	epi_state_t st_nxt;
	logic [2:0] pin_lvl;
	logic [2:0] hit;
	logic [1:0] lvl_mode;
	logic io_run;
	logic wdt_tick;
	logic lvl_wake;
	logic e2_wake;
	logic startup_done;
	logic do_write;
	logic do_read;

	// edge test for pins zero and one per sense code
	function automatic logic edge_hit(input logic [1:0] sense, input logic was, input logic now);
		case (sense)
			epi_pkg::SENSE_CHANGE: edge_hit = was ^ now;
			epi_pkg::SENSE_FALL: edge_hit = was & ~now;
			epi_pkg::SENSE_RISE: edge_hit = ~was & now;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	// start-up ticks for a fuse code
	function automatic logic [5:0] startup_ticks(input logic [1:0] code);
		case (code)
			2'h0: startup_ticks = epi_pkg::STARTUP_TICKS_0;
			2'h1: startup_ticks = epi_pkg::STARTUP_TICKS_1;
			2'h2: startup_ticks = epi_pkg::STARTUP_TICKS_2;
			default: startup_ticks = epi_pkg::STARTUP_TICKS_3;
		endcase
	endfunction

	// pin level: an output-driven pin is seen by the detector too
	assign pin_lvl = (st_r.drv_dir & st_r.drv_val) | (~st_r.drv_dir & pin_in);
	assign pin_out = st_r.drv_val;
	assign pin_oe = st_r.drv_dir;

	// io clock stops only in deep sleep and its start-up
	assign io_run = (st_r.pwr == epi_pkg::PWR_AWAKE) || (st_r.pwr == epi_pkg::PWR_SLEEP && !st_r.deep);
	assign lvl_mode = {st_r.sense1 == epi_pkg::SENSE_LOW, st_r.sense0 == epi_pkg::SENSE_LOW};
	// zero/one edges are only recognised on a running io clock
	assign hit[0] = io_run && edge_hit(st_r.sense0, st_r.prev[0], st_r.sync2[0]);
	assign hit[1] = io_run && edge_hit(st_r.sense1, st_r.prev[1], st_r.sync2[1]);
	// pin two: edge only, polarity bit picks the direction, clock state ignored
	assign hit[2] = st_r.pol2 ? (~st_r.prev[2] & st_r.sync2[2]) : (st_r.prev[2] & ~st_r.sync2[2]);
	assign wdt_tick = st_r.wdt_cnt == 7'(epi_pkg::WDT_CYCLES - 1);
	// level wake needs no io clock; held low level on an enabled pin
	assign lvl_wake = st_r.gie && |(st_r.ena[1:0] & lvl_mode & ~st_r.sync2[1:0]);
	assign e2_wake = st_r.gie && st_r.ena[2] && hit[2];
	assign startup_done = wdt_tick && (st_r.tick_cnt == startup_ticks(st_r.startup_fuse) - 6'h01);
	assign do_write = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
	assign do_read = arvalid && !st_r.rvalid;

	// next state of the whole block
	always_comb begin
		st_nxt = st_r;
		// two-stage synchroniser, first stage feeds only the second
		st_nxt.sync1 = pin_lvl;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev = st_r.sync2;
		st_nxt.wdt_cnt = wdt_tick ? 7'h00 : st_r.wdt_cnt + 7'h01;
		// event flags: event beats vector or write-one clear; level mode keeps clear
		for (int i = 0; i < 3; i++) begin
			st_nxt.flag[i] = hit[i] | (st_r.flag[i] & ~vector_ack[i]);
			if (do_write && st_r.w_lane && st_r.aw_addr == epi_pkg::OFS_FLAG && st_r.w_data[i] && !hit[i]) begin
				st_nxt.flag[i] = 1'b0;
			end
		end
		if (lvl_mode[0]) begin
			st_nxt.flag[0] = 1'b0;
		end
		if (lvl_mode[1]) begin
			st_nxt.flag[1] = 1'b0;
		end
		// request only with both enables; level mode follows the low pin
		for (int i = 0; i < 2; i++) begin
			st_nxt.req[i] = st_r.gie & st_r.ena[i] & (lvl_mode[i] ? ~st_r.sync2[i] : st_r.flag[i]);
		end
		st_nxt.req[2] = st_r.gie & st_r.ena[2] & st_r.flag[2];
		// sticky status, set wins over read clear
		if (do_read && araddr == epi_pkg::OFS_STAT) begin
			st_nxt.stat = 4'h0;
		end
		st_nxt.stat[2:0] = st_nxt.stat[2:0] | hit;
		// power sequencing
		case (st_r.pwr)
			epi_pkg::PWR_AWAKE: begin
				st_nxt.smp_cnt = 2'h0;
				st_nxt.tick_cnt = 6'h00;
			end
			epi_pkg::PWR_SLEEP: begin
				if (!st_r.deep) begin
					if (|st_r.req) begin
						st_nxt.pwr = epi_pkg::PWR_AWAKE;
					end
				end else if (e2_wake) begin
					st_nxt.pwr = epi_pkg::PWR_START;
				end else if (wdt_tick) begin
					// the low level must be seen on two consecutive watchdog samples
					if (lvl_wake && st_r.smp_cnt == 2'(epi_pkg::WDT_SAMPLES - 1)) begin
						st_nxt.pwr = epi_pkg::PWR_START;
					end
					st_nxt.smp_cnt = lvl_wake ? st_r.smp_cnt + 2'h1 : 2'h0;
				end
			end
			epi_pkg::PWR_START: begin
				// wake completes even if the level is gone; the request then stays low
				if (startup_done) begin
					st_nxt.pwr = epi_pkg::PWR_AWAKE;
				end else if (wdt_tick) begin
					st_nxt.tick_cnt = st_r.tick_cnt + 6'h01;
				end
			end
			default: st_nxt.pwr = epi_pkg::PWR_AWAKE;
		endcase
		if (st_r.pwr != epi_pkg::PWR_AWAKE && st_nxt.pwr == epi_pkg::PWR_AWAKE) begin
			st_nxt.stat[epi_pkg::STAT_WAKE] = 1'b1;
		end
		// write channels are taken independently, answer follows both
		if (awvalid && !st_r.aw_ok && !st_r.bvalid) begin
			st_nxt.aw_ok = 1'b1;
			st_nxt.aw_addr = awaddr;
		end
		if (wvalid && !st_r.w_ok && !st_r.bvalid) begin
			st_nxt.w_ok = 1'b1;
			st_nxt.w_data = wdata[7:0];
			st_nxt.w_lane = wstrb[0];
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (do_write) begin
			st_nxt.aw_ok = 1'b0;
			st_nxt.w_ok = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = epi_pkg::RESP_OKAY;
			// every field sits in byte lane zero
			case (st_r.aw_addr)
				epi_pkg::OFS_SENSE: if (st_r.w_lane) begin
					st_nxt.sense0 = st_r.w_data[epi_pkg::POS_SENSE_ZERO +: 2];
					st_nxt.sense1 = st_r.w_data[epi_pkg::POS_SENSE_ONE +: 2];
					st_nxt.pol2 = st_r.w_data[epi_pkg::POS_POL_TWO];
				end
				epi_pkg::OFS_ENABLE: if (st_r.w_lane) begin
					st_nxt.ena = st_r.w_data[2:0];
					st_nxt.gie = st_r.w_data[epi_pkg::POS_GIE];
				end
				epi_pkg::OFS_DRIVE: if (st_r.w_lane) begin
					st_nxt.drv_val = st_r.w_data[2:0];
					st_nxt.drv_dir = st_r.w_data[epi_pkg::POS_DRV_DIR +: 3];
				end
				epi_pkg::OFS_SLEEP: if (st_r.w_lane) begin
					st_nxt.deep = st_r.w_data[epi_pkg::POS_SLP_DEEP];
					st_nxt.startup_fuse = st_r.w_data[epi_pkg::POS_STARTUP +: 2];
					if (st_r.w_data[epi_pkg::POS_SLP_GO] && st_r.pwr == epi_pkg::PWR_AWAKE) begin
						st_nxt.pwr = epi_pkg::PWR_SLEEP;
					end
				end
				epi_pkg::OFS_MASK: if (st_r.w_lane) begin
					st_nxt.mask = st_r.w_data[3:0];
				end
				epi_pkg::OFS_FLAG, epi_pkg::OFS_STAT: ;
				default: st_nxt.bresp = epi_pkg::RESP_SLVERR;
			endcase
		end
		// read answers one cycle after the address is taken
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (do_read) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = epi_pkg::RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			case (araddr)
				epi_pkg::OFS_SENSE: st_nxt.rdata[4:0] = {st_r.pol2, st_r.sense1, st_r.sense0};
				epi_pkg::OFS_ENABLE: st_nxt.rdata[3:0] = {st_r.gie, st_r.ena};
				epi_pkg::OFS_FLAG: st_nxt.rdata[2:0] = st_r.flag;
				epi_pkg::OFS_DRIVE: st_nxt.rdata[6:0] = {st_r.drv_dir, 1'b0, st_r.drv_val};
				epi_pkg::OFS_SLEEP: st_nxt.rdata[6:1] = {st_r.pwr, st_r.startup_fuse, st_r.deep};
				epi_pkg::OFS_STAT: st_nxt.rdata[3:0] = st_r.stat;
				epi_pkg::OFS_MASK: st_nxt.rdata[3:0] = st_r.mask;
				default: st_nxt.rresp = epi_pkg::RESP_SLVERR;
			endcase
		end
	end

	// single state register
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
			st_r.pwr <= epi_pkg::PWR_AWAKE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs
	assign irq_req = st_r.req;
	assign core_asleep = st_r.pwr != epi_pkg::PWR_AWAKE;
	assign io_clk_run = io_run;
	assign irq = |(st_r.stat & st_r.mask);
	assign awready = !st_r.aw_ok && !st_r.bvalid;
	assign wready = !st_r.w_ok && !st_r.bvalid;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign arready = !st_r.rvalid;
	assign rvalid = st_r.rvalid;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_deep_tick;
		st_r.pwr == epi_pkg::PWR_SLEEP && st_r.deep && wdt_tick && !e2_wake;
	endsequence
	sequence s_start_hold;
		st_r.pwr == epi_pkg::PWR_START && !startup_done;
	endsequence

	property p_level_req;
		(st_r.gie && st_r.ena[0] && lvl_mode[0] && !st_r.sync2[0]) [*2] |-> irq_req[0];
	endproperty
	a_level_req: assert property (p_level_req) else $error("level low did not request");
	property p_level_flag;
		lvl_mode[0] |=> !st_r.flag[0] || !lvl_mode[0];
	endproperty
	a_level_flag: assert property (p_level_flag) else $error("flag set in level mode");
	property p_no_edge_stopped;
		(!io_run && !st_r.flag[0]) |=> !st_r.flag[0];
	endproperty
	a_no_edge_stopped: assert property (p_no_edge_stopped) else $error("edge seen without io clock");
	property p_two_rise;
		(st_r.pol2 && !st_r.prev[2] && st_r.sync2[2]) |=> st_r.flag[2];
	endproperty
	a_two_rise: assert property (p_two_rise) else $error("pin two rise missed");
	property p_no_gie;
		!st_r.gie |=> irq_req == 3'h0;
	endproperty
	a_no_gie: assert property (p_no_gie) else $error("request without global enable");
	property p_bad_sample;
		(s_deep_tick and !lvl_wake) |=> st_r.pwr == epi_pkg::PWR_SLEEP && st_r.smp_cnt == 2'h0;
	endproperty
	a_bad_sample: assert property (p_bad_sample) else $error("woke on failed sample");
	property p_start_len;
		s_start_hold |=> st_r.pwr == epi_pkg::PWR_START;
	endproperty
	a_start_len: assert property (p_start_len) else $error("start-up cut short");
	property p_two_wake;
		(st_r.pwr == epi_pkg::PWR_SLEEP && st_r.deep && e2_wake) |=> st_r.pwr == epi_pkg::PWR_START;
	endproperty
	a_two_wake: assert property (p_two_wake) else $error("pin two edge did not wake");
	property p_sync_path;
		$changed(pin_lvl[2]) |-> ##2 st_r.sync2[2] == $past(pin_lvl[2], 2);
	endproperty
	a_sync_path: assert property (p_sync_path) else $error("synchroniser delay wrong");
endmodule

// ==== core/epi_pkg.sv ====
// constants and register map for the external pin interrupt block
// How it works
// - pin driven as output still raises interrupts
// - pins zero/one: edges or level; two: edges
// - level mode requests while pin stays low
// - zero/one edges need running I/O clock
// - level and pin-two edges need no I/O clock
// - asynchronous events wake from any sleep mode
// - I/O clock stops in all but idle sleep
// - level wake sampled twice by watchdog clock
// - wake on two good samples or held level
// - level lost during start-up: wake, no interrupt
// - start-up length chosen by start-up fuses
// - sense codes: low, change, falling, rising
// - pin two polarity: zero falling, one rising
// - request needs own enable and global enable
// - flag sets on event, clears by vector/write-one
package epi_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_SENSE = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_FLAG = 8'h08;
	localparam logic [7:0] OFS_DRIVE = 8'h0C;
	localparam logic [7:0] OFS_SLEEP = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	// field positions
	localparam int POS_SENSE_ZERO = 0;
	localparam int POS_SENSE_ONE = 2;
	localparam int POS_POL_TWO = 4;
	localparam int POS_GIE = 3;
	localparam int POS_DRV_DIR = 4;
	localparam int POS_SLP_GO = 0;
	localparam int POS_SLP_DEEP = 1;
	localparam int POS_STARTUP = 2;
	localparam int STAT_WAKE = 3;
	// sense select codes
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_CHANGE = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int WDT_PERIOD_NS = 1000;
	localparam int WDT_CYCLES = (WDT_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : WDT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int WDT_SAMPLES = 2;
	// start-up length in watchdog ticks per fuse code
	localparam logic [5:0] STARTUP_TICKS_0 = 6'h01;
	localparam logic [5:0] STARTUP_TICKS_1 = 6'h04;
	localparam logic [5:0] STARTUP_TICKS_2 = 6'h10;
	localparam logic [5:0] STARTUP_TICKS_3 = 6'h20;
	// reset value and bus response codes
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// power states
	typedef enum logic [2:0] {
		PWR_AWAKE = 3'b001,
		PWR_SLEEP = 3'b010,
		PWR_START = 3'b100
	} epi_pwr_t;
endpackage

// ==== bench/epi_partner.sv ====
// far-side model: pin wiring and the core's vector acknowledge
`timescale 1ns/1ns
module epi_partner (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bench controls
	input wire logic [2:0] ext_lvl,
	input wire logic ack_en,
	input wire logic [3:0] ack_dly,
	// design side
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic [2:0] irq_req,
	output logic [2:0] pin_in,
	output logic [2:0] vector_ack = 3'h0
);
	logic [2:0] served_r = 3'h0;
	logic [3:0] cnt_r = 4'h0;
	// a driven pin reads back its own value, so software can raise events
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	// core serves each new request once, after a delay the bench picks
	always @(posedge clk) begin
		if (srst || !ack_en) begin
			vector_ack <= 3'h0;
			served_r <= 3'h0;
			cnt_r <= 4'h0;
		end else if (|(irq_req & ~served_r)) begin
			if (cnt_r >= ack_dly) begin
				vector_ack <= irq_req & ~served_r;
				served_r <= served_r | irq_req;
				cnt_r <= 4'h0;
			end else begin
				vector_ack <= 3'h0;
				cnt_r <= cnt_r + 4'h1;
			end
		end else begin
			vector_ack <= 3'h0;
			served_r <= served_r & irq_req; // re-arm once a request drops
		end
	end
endmodule

// ==== bench/external_pin_interrupts_tb.sv ====
// self-checking bench for the external pin interrupt block
`timescale 1ns/1ns
module external_pin_interrupts_tb;
	logic clk = 0;
	logic srst = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ack_en = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] ack_dly = 4'h0, wstrb = 4'hF;
	logic [2:0] ext = 3'h7, pin_in, pin_out, pin_oe, irq_req, vector_ack;
	logic awready, wready, bvalid, arready, rvalid, core_asleep, io_clk_run, irq, o, nl;
	logic [1:0] bresp, rresp;
	int n_mismatch = 0, total_checks = 0, p, c, k, t;
	epi_top dut (.clk(clk), .srst(srst), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req),
		.vector_ack(vector_ack), .core_asleep(core_asleep), .io_clk_run(io_clk_run), .irq(irq), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	epi_partner far (.clk(clk), .srst(srst), .ext_lvl(ext), .ack_en(ack_en), .ack_dly(ack_dly),
		.pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req), .pin_in(pin_in), .vector_ack(vector_ack));
	// free-running 100 MHz clock
	always #5 clk = ~clk;
	// verdict and end of run, also reached when a wait runs out
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// bready and rready stay high after a transfer, so back-to-back calls never drive them twice in one step
	// one write, address and data offered together, response awaited
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
		int n;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				chk("bresp", bresp, er);
				break;
			end
		end
		if (n == 50) begin
			chk("bvalid", 0, 1);
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
		int n;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		v = 32'h0;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				v = rdata;
				chk("rresp", rresp, er);
				break;
			end
		end
		if (n == 50) begin
			chk("rvalid", 0, 1);
			conclude();
		end
	endtask
	// bounded wait for the end of sleep or start-up
	task automatic wait_awake(output int n);
		for (n = 0; n < 5000 && core_asleep !== 1'b0; n++) @(posedge clk);
		if (n == 5000) begin
			chk("awake", 0, 1);
			conclude();
		end
	endtask
	// expected flag for a sense code and a pin step
	function automatic logic fx(input int s, input logic a, input logic b);
		case (2'(s))
			epi_pkg::SENSE_CHANGE: return a ^ b;
			epi_pkg::SENSE_FALL: return a & ~b;
			epi_pkg::SENSE_RISE: return ~a & b;
			default: return 1'b0;
		endcase
	endfunction
	function automatic int nt(input int f);
		return f == 0 ? epi_pkg::STARTUP_TICKS_0 : f == 1 ? epi_pkg::STARTUP_TICKS_1 :
			f == 2 ? epi_pkg::STARTUP_TICKS_2 : epi_pkg::STARTUP_TICKS_3;
	endfunction
	// main sequence
	initial begin
		void'($urandom(32'h5EF63708));
		repeat (5) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		// reset map, unmapped word last
		for (k = 0; k < 8; k++) begin
			rd(8'(4 * k), d, k == 7 ? epi_pkg::RESP_SLVERR : epi_pkg::RESP_OKAY);
			chk("reset_val", d, k == 4 ? 32'h10 : 32'h0);
		end
		wr(8'h1C, 32'hFF, epi_pkg::RESP_SLVERR);
		// a write with no byte lane enabled answers okay and changes nothing
		wstrb <= 4'h0;
		wr(epi_pkg::OFS_ENABLE, 32'hF);
		wstrb <= 4'hF;
		rd(epi_pkg::OFS_ENABLE, d);
		chk("strobe_off", d, 32'h0);
		// every edge code on pins zero and one, falling and rising on pin two, random steps, first step forced
		for (p = 0; p < 3; p++) for (c = 1; c < 4; c++) begin
			if (p == 2 && c == 1) continue;
			wr(epi_pkg::OFS_SENSE, p == 2 ? (c == 3 ? 32'h10 : 32'h0) : 32'(c << (2 * p)));
			wr(epi_pkg::OFS_ENABLE, 32'h8 | (32'h1 << p));
			for (k = 0; k < 6; k++) begin
				wr(epi_pkg::OFS_FLAG, 32'h7);
				o = ext[p];
				nl = k == 0 ? ~o : 1'($urandom_range(0, 1));
				ext[p] <= nl;
				repeat (6) @(posedge clk);
				rd(epi_pkg::OFS_FLAG, d);
				chk("flag", d[p], fx(c, o, nl));
				chk("irq_req", irq_req[p], fx(c, o, nl));
			end
		end
		// low level on pins zero and one, then global enable off
		ext <= 3'h7;
		wr(epi_pkg::OFS_SENSE, 32'h0);
		wr(epi_pkg::OFS_ENABLE, 32'hB);
		ext[1:0] <= 2'b00;
		for (k = 0; k < 3; k++) begin
			repeat (20) @(posedge clk);
			chk("level_req", irq_req[1:0], 2'h3);
		end
		rd(epi_pkg::OFS_FLAG, d);
		chk("level_flag", d[1:0], 2'h0);
		wr(epi_pkg::OFS_ENABLE, 32'h3);
		repeat (4) @(posedge clk);
		chk("no_gie", irq_req, 3'h0);
		ext <= 3'h7;
		// software raises pin two by driving it, status and mask, then the core acks
		rd(epi_pkg::OFS_STAT, d);
		wr(epi_pkg::OFS_SENSE, 32'h10);
		wr(epi_pkg::OFS_ENABLE, 32'hC);
		wr(epi_pkg::OFS_MASK, 32'h4);
		wr(epi_pkg::OFS_DRIVE, 32'h40);
		ext[2] <= 0;
		wr(epi_pkg::OFS_FLAG, 32'h7);
		wr(epi_pkg::OFS_DRIVE, 32'h44);
		repeat (6) @(posedge clk);
		chk("drive", {pin_oe, pin_out}, 6'h24);
		chk("sw_irq", {irq_req[2], irq}, 2'h3);
		rd(epi_pkg::OFS_STAT, d);
		chk("stat", d, 32'h4);
		repeat (3) @(posedge clk);
		chk("irq_clr", irq, 0);
		ack_dly <= 4'($urandom_range(0, 15));
		ack_en <= 1;
		for (t = 0; t < 40 && irq_req[2] !== 1'b0; t++) @(posedge clk);
		rd(epi_pkg::OFS_FLAG, d);
		chk("ack_clear", {d[2], irq_req[2]}, 2'h0);
		ack_en <= 0;
		wr(epi_pkg::OFS_DRIVE, 32'h0);
		// deep sleep: synchronous edge ignored, pin two edge wakes
		ext <= 3'h0;
		wr(epi_pkg::OFS_SENSE, 32'h13);
		wr(epi_pkg::OFS_ENABLE, 32'hD);
		wr(epi_pkg::OFS_FLAG, 32'h7);
		wr(epi_pkg::OFS_SLEEP, 32'h3);
		repeat (3) @(posedge clk);
		chk("deep_clk", {core_asleep, io_clk_run}, 2'b10);
		rd(epi_pkg::OFS_SLEEP, d);
		chk("sleep_reg", d, 32'h22);
		ext[0] <= 1;
		repeat (10) @(posedge clk);
		chk("edge_off", {core_asleep, irq_req[0]}, 2'b10);
		ext[2] <= 1;
		wait_awake(t);
		chk("async_wake", io_clk_run, 1);
		// idle sleep keeps the clock, so a clocked edge wakes at once
		ext[0] <= 0;
		repeat (6) @(posedge clk);
		wr(epi_pkg::OFS_FLAG, 32'h7);
		wr(epi_pkg::OFS_SLEEP, 32'h1);
		repeat (2) @(posedge clk);
		chk("idle_clk", {core_asleep, io_clk_run}, 2'b11);
		ext[0] <= 1;
		wait_awake(t);
		chk("idle_wake", t < 12, 1);
		// level wake for each start-up fuse code, level held throughout
		wr(epi_pkg::OFS_SENSE, 32'h0);
		wr(epi_pkg::OFS_ENABLE, 32'h9);
		for (k = 0; k < 4; k++) begin
			wr(epi_pkg::OFS_SLEEP, 32'(3 + 4 * k));
			ext[0] <= 0; // source holds the level until wake-up ends
			wait_awake(t);
			chk("wake_time", t >= 100 * nt(k) + 90 && t <= 100 * nt(k) + 320, 1);
			repeat (4) @(posedge clk);
			chk("level_irq", irq_req[0], 1);
			ext[0] <= 1;
			repeat (6) @(posedge clk);
		end
		// level passes both samples but is gone before start-up ends
		rd(epi_pkg::OFS_STAT, d);
		wr(epi_pkg::OFS_SLEEP, 32'hF);
		ext[0] <= 0;
		repeat (250) @(posedge clk);
		ext[0] <= 1;
		wait_awake(t);
		repeat (6) @(posedge clk);
		chk("lost_level", irq_req[0], 0);
		rd(epi_pkg::OFS_STAT, d);
		chk("wake_stat", d[3], 1);
		conclude();
	end
endmodule
